// *** verilog/hais_ident_store.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hais_regs.svh"
module hais_ident_store #(
	parameter int          CODE_W  = 14,
	parameter logic [37:0] UNIQ_ID = 38'h0012345678 // arbitrary value
) (
	input  wire logic                   sys_clk,    // 125 MHz clock
	input  wire logic                   resetn,     // async reset, low
	input  wire logic [9:0]             regAddr,    // byte address
	input  wire logic [31:0]            regWdata,   // write data
	input  wire logic                   regWr,      // write strobe
	input  wire logic                   regRd,      // read strobe
	output logic      [31:0]            regRdata,   // read data, cycle after strobe
	input  wire hais_pkg::hais_sensor_type sensorMem, // sensor memory items
	input  wire logic [CODE_W-1:0]      measCode,   // measurement span code
	input  wire logic [CODE_W-1:0]      cvCode,     // controlled-variable code
	output logic      [CODE_W-1:0]      loopCode,   // code to current dac
	output logic                        loopFixed,  // loop parked at floor
	output logic                        frameForUs  // pulse: good frame for this device
);
	import hais_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [3:0]       pollAddr;
		logic             ctrlMode;
		logic [7:0]       day;
		logic [7:0]       month;
		logic [7:0]       year;
		logic [2:0]       flgType;
		logic [1:0]       flgMat;
		logic [1:0]       oring;
		logic             indicator;
		logic             sealSide;
		logic [2:0]       sealFluid;
		logic [1:0]       sealDiaph;
		hais_frm_type     frm;
		logic [7:0]       cnt;
		logic [7:0]       chk;
		logic             longAddr;
		logic [39:0]      addrSh;
		logic             firstAddr;
		logic             primary;
		logic             burst;
		logic [7:0]       cmd;
		hais_cls_type     cls;
		logic             done;
		logic             chkOk;
		logic             match;
		logic             hit;
		logic             rejected;
		logic [31:0]      rdata;
	} hais_state_type;

	hais_state_type q, d;
	hais_bus_type   bus;

	assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

	// ****************************************
	// decode helpers
	// ****************************************
	logic       textSel;
	logic [5:0] textIdx;
	logic [7:0] wByte;
	logic [7:0] chkNext;
	logic       textWr;
	logic [7:0] textMem [`HAIS_TEXT_WORDS];

	assign textSel = (bus.addr[9:8] == `HAIS_TEXT_PAGE) && (bus.addr[7:2] < `HAIS_TEXT_WORDS);
	assign textIdx = bus.addr[7:2];
	assign wByte   = bus.wdata[7:0];
	assign chkNext = q.chk ^ wByte;
	assign textWr  = bus.wr && textSel;

	function automatic hais_cls_type classify(input logic [7:0] c);
		hais_cls_type r;
		r = CLS_NONE;
		if (c <= `HAIS_UNIV_MAX)
			r = CLS_UNIV;
		else if (c >= `HAIS_COMMON_MIN && c <= `HAIS_COMMON_MAX)
			r = CLS_COMMON;
		else if (c >= `HAIS_SPEC_MIN && c <= `HAIS_SPEC_MAX)
			r = CLS_SPEC;
		return r;
	endfunction : classify

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [31:0] rv;
		logic        matchNow;
		rv       = '0;
		matchNow = 1'b0;
		d        = q;
		d.hit    = 1'b0;
		d.rdata  = '0;

		// short address: low four bits; long address: 38 bits of unique id
		if (q.longAddr)
			matchNow = (q.addrSh[37:0] == UNIQ_ID);
		else
			matchNow = (q.addrSh[3:0] == q.pollAddr);

		if (bus.wr) begin
			if (textSel) begin
				// text bytes go to the entry flops below
			end else begin
				unique case (bus.addr)
					`HAIS_OFF_CFG: begin
						d.pollAddr = bus.wdata[3:0];
						d.ctrlMode = bus.wdata[4];
					end
					`HAIS_OFF_DATE: begin
						// out-of-range day or month keeps the old byte
						if (bus.wdata[7:0] >= `HAIS_DAY_MIN && bus.wdata[7:0] <= `HAIS_DAY_MAX)
							d.day = bus.wdata[7:0];
						if (bus.wdata[15:8] >= `HAIS_MON_MIN && bus.wdata[15:8] <= `HAIS_MON_MAX)
							d.month = bus.wdata[15:8];
						d.year = bus.wdata[23:16];
					end
					`HAIS_OFF_CONSTR: begin
						// coded fields only take a listed code; indicator and seal side bits take any value
						if (bus.wdata[2:0] <= `HAIS_FLG_TYPE_MAX)
							d.flgType = bus.wdata[2:0];
						if (bus.wdata[5:4] <= `HAIS_FLG_MAT_MAX)
							d.flgMat = bus.wdata[5:4];
						if (bus.wdata[7:6] <= `HAIS_ORING_MAX)
							d.oring = bus.wdata[7:6];
						d.indicator = bus.wdata[8];
						d.sealSide  = bus.wdata[9];
						if (bus.wdata[14:12] <= `HAIS_SFLUID_MAX)
							d.sealFluid = bus.wdata[14:12];
						if (bus.wdata[17:16] <= `HAIS_SDIAPH_MAX)
							d.sealDiaph = bus.wdata[17:16];
					end
					`HAIS_OFF_SENSOR, `HAIS_OFF_SRANGE: begin
						d.rejected = 1'b1;
					end
					`HAIS_OFF_REJ: begin
						if (bus.wdata[0])
							d.rejected = 1'b0;
					end
					`HAIS_OFF_FCTRL: begin
						if (bus.wdata[0]) begin
							d.frm = FRM_DELIM;
							d.chk = '0;
						end else begin
							d.frm = FRM_IDLE;
						end
					end
					`HAIS_OFF_FSTAT: begin
						if (bus.wdata[0])
							d.done = 1'b0;
					end
					`HAIS_OFF_FBYTE: begin
						d.chk = chkNext;
						unique case (q.frm)
							FRM_IDLE: begin
								d.chk = q.chk;
							end
							FRM_DELIM: begin
								d.longAddr  = wByte[7];
								d.cnt       = {5'b0, wByte[7] ? `HAIS_LONG_ABYTES : `HAIS_SHORT_ABYTES};
								d.addrSh    = '0;
								d.firstAddr = 1'b1;
								d.frm       = FRM_ADDR;
							end
							FRM_ADDR: begin
								// first address byte: master bit and burst bit
								if (q.firstAddr) begin
									d.primary = wByte[7];
									d.burst   = wByte[6];
									d.addrSh  = {32'b0, 2'b00, wByte[5:0]};
								end else begin
									d.addrSh = {q.addrSh[31:0], wByte};
								end
								d.firstAddr = 1'b0;
								d.cnt       = q.cnt - 8'd1;
								if (q.cnt == 8'd1)
									d.frm = FRM_CMD;
							end
							FRM_CMD: begin
								d.cmd = wByte;
								d.cls = classify(wByte);
								d.frm = FRM_BCNT;
							end
							FRM_BCNT: begin
								d.cnt = wByte;
								d.frm = (wByte == 8'd0) ? FRM_CHK : FRM_DATA;
							end
							FRM_DATA: begin
								d.cnt = q.cnt - 8'd1;
								if (q.cnt == 8'd1)
									d.frm = FRM_CHK;
							end
							FRM_CHK: begin
								// xor over every byte, checksum included, must be zero
								d.chkOk = (chkNext == 8'h00);
								d.match = matchNow;
								d.done  = 1'b1;
								d.hit   = (chkNext == 8'h00) && matchNow;
								d.frm   = FRM_IDLE;
							end
							default: begin
								d.frm = FRM_IDLE;
							end
						endcase
					end
					default: begin
					end
				endcase
			end
		end

		if (bus.rd) begin
			if (textSel) begin
				rv = {24'b0, textMem[textIdx]};
			end else begin
				unique case (bus.addr)
					`HAIS_OFF_CFG:    rv = {27'b0, q.ctrlMode, q.pollAddr};
					`HAIS_OFF_LOOP:   rv = {17'b0, loopFixed, loopCode};
					`HAIS_OFF_DATE:   rv = {8'b0, q.year, q.month, q.day};
					`HAIS_OFF_CONSTR: rv = {14'b0, q.sealDiaph, 1'b0, q.sealFluid, 2'b0, q.sealSide,
						q.indicator, q.oring, q.flgMat, 1'b0, q.flgType};
					`HAIS_OFF_SENSOR: rv = {16'b0, sensorMem.sensorType, 1'b0, sensorMem.diaphragm,
						1'b0, sensorMem.fluid};
					`HAIS_OFF_SRANGE: rv = {16'b0, sensorMem.range};
					`HAIS_OFF_REJ:    rv = {31'b0, q.rejected};
					`HAIS_OFF_FCTRL:  rv = {29'b0, q.frm};
					`HAIS_OFF_FSTAT:  rv = {16'b0, q.cmd, q.cls, q.burst, q.primary,
						q.match, q.chkOk, q.longAddr, q.done};
					default:          rv = '0;
				endcase
			end
			d.rdata = rv;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			q          <= '0;
			q.day      <= `HAIS_DAY_RST;
			q.month    <= `HAIS_MON_RST;
			q.year     <= `HAIS_YEAR_RST;
			q.frm      <= FRM_IDLE;
			q.cls      <= CLS_NONE;
		end else begin
			q <= d;
		end
	end

	assign regRdata   = q.rdata;
	assign frameForUs = q.hit;

	// ****************************************
	// text records: tag, descriptor, message
	// ****************************************
	// one byte of flops per entry keeps the text out of the wide state copy
	generate
		for (genvar i = 0; i < `HAIS_TEXT_WORDS; i++) begin : g_text
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					textMem[i] <= `HAIS_CHAR_RST;
				end else if (textWr && textIdx == 6'(i)) begin
					textMem[i] <= wByte;
				end
			end
		end
	endgenerate

	// ****************************************
	// loop current selection
	// ****************************************
	// kept in its own module: only address, mode and the two codes feed it
	hais_loop_sel #(
		.CODE_W (CODE_W)
	) u_loop (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.pollAddr  (q.pollAddr),
		.ctrlMode  (q.ctrlMode),
		.measCode  (measCode),
		.cvCode    (cvCode),
		.loopCode  (loopCode),
		.loopFixed (loopFixed)
	);
endmodule : hais_ident_store
`default_nettype wire

// *** verilog/hais_regs.svh ***
`ifndef HAIS_REGS_SVH
`define HAIS_REGS_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define HAIS_ADDR_W        10
`define HAIS_OFF_CFG       10'h000
`define HAIS_OFF_LOOP      10'h004
`define HAIS_OFF_DATE      10'h008
`define HAIS_OFF_CONSTR    10'h00c
`define HAIS_OFF_SENSOR    10'h010
`define HAIS_OFF_SRANGE    10'h014
`define HAIS_OFF_FCTRL     10'h018
`define HAIS_OFF_FBYTE     10'h01c
`define HAIS_OFF_FSTAT     10'h020
`define HAIS_OFF_REJ       10'h024
`define HAIS_TEXT_PAGE     2'b01
`define HAIS_TEXT_WORDS    6'd56
`define HAIS_TAG_FIRST     6'd0
`define HAIS_DESC_FIRST    6'd8
`define HAIS_MSG_FIRST     6'd24

// ****************************************
// field limits and reset values
// ****************************************
`define HAIS_DAY_MIN       8'd1
`define HAIS_DAY_MAX       8'd31
`define HAIS_MON_MIN       8'd1
`define HAIS_MON_MAX       8'd12
`define HAIS_DAY_RST       8'd1
`define HAIS_MON_RST       8'd1
`define HAIS_YEAR_RST      8'd0
`define HAIS_CHAR_RST      8'h20
`define HAIS_FLG_TYPE_MAX  3'd6
`define HAIS_FLG_MAT_MAX   2'd2
`define HAIS_ORING_MAX     2'd3
`define HAIS_SFLUID_MAX    3'd4
`define HAIS_SDIAPH_MAX    2'd2
`define HAIS_LOOP_FLOOR    14'h0000

// ****************************************
// link-layer frame constants
// ****************************************
`define HAIS_SHORT_ABYTES  3'd1
`define HAIS_LONG_ABYTES   3'd5
`define HAIS_UNIV_MAX      8'd30
`define HAIS_COMMON_MIN    8'd32
`define HAIS_COMMON_MAX    8'd126
`define HAIS_SPEC_MIN      8'd128
`define HAIS_SPEC_MAX      8'd253

`endif

// *** verilog/hais_pkg.sv ***
`default_nettype none
package hais_pkg;

	typedef struct packed {
		logic [9:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} hais_bus_type;

	typedef struct packed {
		logic [2:0]  fluid;
		logic [2:0]  diaphragm;
		logic [7:0]  sensorType;
		logic [15:0] range;
	} hais_sensor_type;

	typedef enum logic [2:0] {
		FRM_IDLE  = 3'b000,
		FRM_DELIM = 3'b001,
		FRM_ADDR  = 3'b010,
		FRM_CMD   = 3'b011,
		FRM_BCNT  = 3'b100,
		FRM_DATA  = 3'b101,
		FRM_CHK   = 3'b110
	} hais_frm_type;

	typedef enum logic [1:0] {
		CLS_NONE   = 2'b00,
		CLS_UNIV   = 2'b01,
		CLS_COMMON = 2'b10,
		CLS_SPEC   = 2'b11
	} hais_cls_type;

endpackage : hais_pkg
`default_nettype wire

// *** verilog/hais_loop_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hais_regs.svh"
module hais_loop_sel #(
	parameter int CODE_W = 14
) (
	input  wire logic              sys_clk,    // system clock
	input  wire logic              resetn,     // async reset, low
	input  wire logic [3:0]        pollAddr,   // polling address
	input  wire logic              ctrlMode,   // 1 = controller mode
	input  wire logic [CODE_W-1:0] measCode,   // measurement span code
	input  wire logic [CODE_W-1:0] cvCode,     // controlled-variable code
	output logic      [CODE_W-1:0] loopCode,   // code to current dac
	output logic                   loopFixed   // current parked at floor
);
	import hais_pkg::*;

	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic              fixed;
	} hais_loop_type;

	hais_loop_type q, d;

	// frame traffic never reaches this path; of host access only a config write can bump the loop
	always_comb begin
		d = q;
		if (ctrlMode) begin
			d.code  = cvCode;
			d.fixed = 1'b0;
		end else if (pollAddr == 4'h0) begin
			d.code  = measCode;
			d.fixed = 1'b0;
		end else begin
			d.code  = CODE_W'(`HAIS_LOOP_FLOOR);
			d.fixed = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign loopCode  = q.code;
	assign loopFixed = q.fixed;
endmodule : hais_loop_sel
`default_nettype wire

// *** tb/hais_store_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hais_regs.svh"
// ****
// port checks
// ****
module hais_store_chk
	import hais_pkg::*;
#(
	parameter int CODE_W = 14
) (
	input wire logic              sys_clk,    // clock
	input wire logic              resetn,     // reset, low
	input wire logic [9:0]        regAddr,    // address
	input wire logic [31:0]       regWdata,   // write data
	input wire logic              regWr,      // write strobe
	input wire logic              regRd,      // read strobe
	input wire logic [31:0]       regRdata,   // read data
	input wire hais_sensor_type   sensorMem,  // sensor items
	input wire logic [CODE_W-1:0] measCode,   // measurement
	input wire logic [CODE_W-1:0] cvCode,     // controlled variable
	input wire logic [CODE_W-1:0] loopCode,   // dac code
	input wire logic              loopFixed,  // parked
	input wire logic              frameForUs  // good frame
);
	logic [1:0] upCnt_q;
	// loop output is only meaningful once reset has settled
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			upCnt_q <= 2'h0;
		else if (upCnt_q != 2'h3)
			upCnt_q <= upCnt_q + 2'h1;
	end
	function automatic logic [1:0] clsOf(input logic [7:0] c);
		if (c <= `HAIS_UNIV_MAX)
			return 2'h1;
		if (c >= `HAIS_COMMON_MIN && c <= `HAIS_COMMON_MAX)
			return 2'h2;
		if (c >= `HAIS_SPEC_MIN && c <= `HAIS_SPEC_MAX)
			return 2'h3;
		return 2'h0;
	endfunction : clsOf
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	rd_idle_a: assert property (!regRd |=> regRdata == 32'h0)
		else $error("read data not idle");
	text_byte_a: assert property (regRd && regAddr[9:8] == `HAIS_TEXT_PAGE |=> regRdata[31:8] == 24'h0)
		else $error("text word wider than a byte");
	date_range_a: assert property (regRd && regAddr == `HAIS_OFF_DATE |=> regRdata[7:0] inside {[1:31]}
		&& regRdata[15:8] inside {[1:12]} && regRdata[31:24] == 8'h0) else $error("date out of range");
	sensor_ro_a: assert property (regRd && regAddr == `HAIS_OFF_SENSOR |=> regRdata == {16'h0,
		$past(sensorMem.sensorType), 1'b0, $past(sensorMem.diaphragm), 1'b0, $past(sensorMem.fluid)})
		else $error("sensor item mismatch");
	range_ro_a: assert property (regRd && regAddr == `HAIS_OFF_SRANGE |=> regRdata == {16'h0, $past(sensorMem.range)})
		else $error("sensor range mismatch");
	class_map_a: assert property (regRd && regAddr == `HAIS_OFF_FSTAT |=>
		!regRdata[0] || regRdata[7:6] == clsOf(regRdata[15:8])) else $error("command class wrong");
	frame_pulse_a: assert property (frameForUs |=> !frameForUs)
		else $error("frame pulse too long");
	frame_cause_a: assert property (frameForUs |-> $past(regWr) && $past(regAddr) == `HAIS_OFF_FBYTE)
		else $error("frame pulse without byte");
	floor_code_a: assert property (loopFixed |-> loopCode == '0)
		else $error("parked loop not at floor");
	loop_source_a: assert property (upCnt_q == 2'h3 && $stable(measCode) && $stable(cvCode) |=>
		(loopFixed && loopCode == '0) || (!loopFixed && (loopCode == $past(measCode) || loopCode == $past(cvCode))))
		else $error("loop code from no source");
	loop_quiet_a: assert property (upCnt_q == 2'h3 && regWr && regAddr inside {`HAIS_OFF_FCTRL, `HAIS_OFF_FBYTE}
		&& !$past(regWr) && $stable(measCode) && $stable(cvCode) |=> $stable(loopCode) && $stable(loopFixed))
		else $error("host traffic moved loop");
endmodule : hais_store_chk

bind hais_ident_store hais_store_chk #(.CODE_W(CODE_W)) u_chk (.sys_clk(sys_clk), .resetn(resetn),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.sensorMem(sensorMem), .measCode(measCode), .cvCode(cvCode), .loopCode(loopCode),
	.loopFixed(loopFixed), .frameForUs(frameForUs));
`default_nettype wire

// *** tb/hais_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// host master: short-frame builder
// ****
module hais_master_model (
	input wire logic        isPrimary,  // sender is primary master
	input wire logic [3:0]  destAddr,   // polling address aimed at
	input wire logic [7:0]  cmd,        // command number
	input wire logic        badChk,     // corrupt the checksum
	output logic     [39:0] frame       // delimiter in top byte
);
	logic [7:0] adrByte;
	assign adrByte = {isPrimary, 3'h0, destAddr};
	assign frame[39:8] = {8'h02, adrByte, cmd, 8'h00};
	assign frame[7:0] = 8'h02 ^ adrByte ^ cmd ^ {7'h0, badChk};
endmodule : hais_master_model
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hais_regs.svh"
module testbench;
	import hais_pkg::*;
	logic            sys_clk = 1'b0;
	logic            resetn = 1'b0;
	logic [9:0]      regAddr = 10'h0;
	logic [31:0]     regWdata = 32'h0;
	logic            regWr = 1'b0;
	logic            regRd = 1'b0;
	logic [31:0]     regRdata;
	hais_sensor_type sensorMem = {3'h3, 3'h4, 8'h5a, 16'hbeef};
	logic [13:0]     measCode = 14'h1234;
	logic [13:0]     cvCode = 14'h0abc;
	logic [13:0]     loopCode;
	logic            loopFixed;
	logic            frameForUs;
	logic            isPrimary = 1'b1;
	logic [7:0]      cmd = 8'h0;
	logic            badChk = 1'b0;
	logic [39:0]     frame;
	int              nErrors = 0;
	int              numChecks = 0;
	int              edges[6] = '{0, 7, 8, 23, 24, 55};
	logic [4:0]      cfgs[6] = '{5'h05, 5'h0f, 5'h01, 5'h00, 5'h15, 5'h10};
	logic [7:0]      cmds[4] = '{8'd0, 8'd48, 8'd130, 8'd254};
	logic [1:0]      clss[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
	// long frame to the unique id: delimiter, five address bytes, cmd, count, one data byte, checksum
	logic [7:0]      lng[10] = '{8'h82, 8'h80, 8'h12, 8'h34, 8'h56, 8'h78, 8'h80, 8'h01, 8'h55, 8'hde};

	always #4 sys_clk = ~sys_clk;

	// unique id value is arbitrary
	hais_ident_store #(.UNIQ_ID(38'h0012345678)) dut (.sys_clk(sys_clk), .resetn(resetn),
		.regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sensorMem(sensorMem), .measCode(measCode),
		.cvCode(cvCode), .loopCode(loopCode), .loopFixed(loopFixed), .frameForUs(frameForUs));
	hais_master_model host (.isPrimary(isPrimary), .destAddr(4'h0), .cmd(cmd), .badChk(badChk), .frame(frame));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		numChecks++;
		if (g !== e) begin
			nErrors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rc(input logic [9:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 chk(regRdata, e);
	endtask : rc
	task automatic frm(input logic p, input logic [7:0] c, input logic bad, input logic expHit,
		input logic [13:0] expLoop);
		isPrimary = p;
		cmd = c;
		badChk = bad;
		wr(`HAIS_OFF_FCTRL, 32'h1);
		for (int i = 4; i >= 0; i--)
			wr(`HAIS_OFF_FBYTE, {24'h0, frame[i*8 +: 8]});
		#1 chk({31'h0, frameForUs}, {31'h0, expHit});
		chk({18'h0, loopCode}, {18'h0, expLoop});
	endtask : frm
	task automatic results;
		$display("checks %0d errors %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	// a hang costs one mismatch and still ends through the verdict
	initial begin
		#100000;
		nErrors++;
		results();
	end

	initial begin
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		rc(`HAIS_OFF_CFG, 32'h0);
		rc(`HAIS_OFF_DATE, 32'h101);
		for (int i = 0; i < 56; i++)
			rc(10'h100 + 10'(4 * i), 32'h20);
		foreach (edges[k]) begin
			wr(10'h100 + 10'(4 * edges[k]), 32'hffffff41 + edges[k]);
			rc(10'h100 + 10'(4 * edges[k]), 32'h41 + edges[k]);
		end
		wr(`HAIS_OFF_DATE, 32'h00ff0c1f);
		rc(`HAIS_OFF_DATE, 32'h00ff0c1f);
		wr(`HAIS_OFF_DATE, 32'h00050d00);
		rc(`HAIS_OFF_DATE, 32'h00050c1f);
		rc(`HAIS_OFF_SRANGE, 32'hbeef);
		wr(`HAIS_OFF_SENSOR, 32'h0);
		rc(`HAIS_OFF_SENSOR, 32'h5a43);
		rc(`HAIS_OFF_REJ, 32'h1);
		wr(`HAIS_OFF_REJ, 32'h1);
		rc(`HAIS_OFF_REJ, 32'h0);
		wr(`HAIS_OFF_CONSTR, 32'h243e6);
		rc(`HAIS_OFF_CONSTR, 32'h243e6);
		wr(`HAIS_OFF_CONSTR, 32'h7);
		rc(`HAIS_OFF_CONSTR, 32'h6);
		foreach (cfgs[k]) begin
			wr(`HAIS_OFF_CFG, {27'h0, cfgs[k]});
			repeat (2) @(posedge sys_clk);
			// park only for a nonzero address in transmitter mode
			rc(`HAIS_OFF_LOOP, cfgs[k][4] ? {18'h0, cvCode} : (cfgs[k] == 5'h0 ? {18'h0, measCode} : 32'h4000));
		end
		wr(`HAIS_OFF_CFG, 32'h0);
		@(posedge sys_clk);
		measCode <= 14'h3fff;
		repeat (3) @(posedge sys_clk);
		chk({18'h0, loopCode}, {18'h0, measCode});
		for (int p = 0; p < 2; p++)
			foreach (cmds[k]) begin
				frm(p[0], cmds[k], 1'b0, 1'b1, 14'h3fff);
				rc(`HAIS_OFF_FSTAT, {16'h0, cmds[k], clss[k], 1'b0, p[0], 4'hd});
				wr(`HAIS_OFF_FSTAT, 32'h1);
			end
		frm(1'b1, 8'h0, 1'b1, 1'b0, 14'h3fff);
		rc(`HAIS_OFF_FSTAT, 32'h59);
		wr(`HAIS_OFF_CFG, 32'h3);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, loopFixed}, 32'h1);
		measCode <= 14'h1234;
		wr(`HAIS_OFF_CFG, 32'h3);
		// parked loop stays at the floor code while a frame for another address goes by
		frm(1'b1, 8'h0, 1'b0, 1'b0, 14'h0);
		rc(`HAIS_OFF_FSTAT, 32'h55);
		wr(`HAIS_OFF_FCTRL, 32'h1);
		rc(`HAIS_OFF_FCTRL, 32'h1);
		wr(`HAIS_OFF_FCTRL, 32'h0);
		wr(`HAIS_OFF_FBYTE, 32'h02);
		rc(`HAIS_OFF_FCTRL, 32'h0);
		wr(`HAIS_OFF_FCTRL, 32'h1);
		foreach (lng[k])
			wr(`HAIS_OFF_FBYTE, {24'h0, lng[k]});
		#1 chk({31'h0, frameForUs}, 32'h1);
		rc(`HAIS_OFF_FSTAT, 32'h80df);
		results();
	end
endmodule : testbench
`default_nettype wire
